/* File: verilog/ictr_counter.sv */
// One 16-bit interval counter running modes 0 to 4.
// How it works
// - Mode 0 output low until zero, then high.
// - Gate low pauses counting; mode 1 ignores it.
// - Mode 0 load pulse does not decrement.
// - Mode 0 first byte holds, drops output.
// - Mode 0 count loads even with gate low.
// - Mode 1 output falls after trigger, rises at zero.
// - Mode 1 every trigger reloads and restarts pulse.
// - Mode 1 new count waits for a retrigger.
// - Mode 2 one-pulse low at one, reload, repeat.
// - Mode 2 gate low forces high; trigger reloads.
// - Mode 2 loads on the pulse after writing.
// - Mode 2 new count waits for trigger or end.
// - Mode 3 square wave; gate low forces high.
// - Mode 3 loads after write or trigger.
// - Mode 3 even counts step by two.
// - Mode 3 odd counts split high and low.
// - Mode 4 strobes low N plus one after write.
// - Mode 4 reloads after second byte only.
// - Load and decrement on the counter clock's fall.
// - Gate rise caught in flop, taken at clock rise.
// - Load copies buffer to counter; zero means maximum.
// - Modes 0, 1, 4 wrap past zero.
`timescale 1ns/100ps
module ictr_counter (
    // System clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Control word write from the host.
    input  wire logic                 cw_wr,
    input  ictr_pkg::ictr_cw_t        cw,
    // Count byte write from the host.
    input  wire logic                 cnt_wr,
    input  wire logic [7:0]           cnt_byte,
    // Counter pins.
    input  wire logic                 cnt_clk,
    input  wire logic                 gate,
    output logic                      pulse_out,
    // Status for the host side.
    output logic [15:0]               count_now,
    output logic                      null_count,
    output logic                      byte_pending
);
    import ictr_pkg::*;

    ictr_state_t s_reg;
    ictr_state_t s_next;
    ictr_edge_t  clk_e;
    ictr_edge_t  gate_e;

    ictr_edge u_clk_edge (
        .clk    (clk),
        .rst    (rst),
        .sig    (cnt_clk),
        .edge_o (clk_e)
    );

    ictr_edge u_gate_edge (
        .clk    (clk),
        .rst    (rst),
        .sig    (gate),
        .edge_o (gate_e)
    );

    // Steps down by one in binary or in four BCD digits; zero wraps.
    function automatic logic [15:0] dec1(input logic [15:0] v,
                                         input logic bcd);
        logic [15:0] r;
        logic        br;
        r  = v;
        br = 1'b1;
        if (!bcd) begin
            r = v - ICTR_CE_ONE;
        end else begin
            for (int d = 0; d < ICTR_BCD_DIGITS; d++) begin
                if (br) begin
                    if (r[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = ICTR_BCD_NINE;
                    end else begin
                        r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
                        br = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    // Steps down by one, two or three.
    function automatic logic [15:0] dec_by(input logic [15:0] v,
                                           input logic [1:0] k,
                                           input logic bcd);
        logic [15:0] r;
        r = v;
        for (int i = 0; i < 3; i++) begin
            if (i < int'(k)) begin
                r = dec1(r, bcd);
            end
        end
        return r;
    endfunction

    logic [15:0] dec_one;
    logic [15:0] sq_rest;
    logic [1:0]  sq_step;
    logic        cnt_done;
    logic [15:0] cnt_word;

    always_comb begin
        dec_one = dec1(s_reg.ce, s_reg.bcd);
        if (!s_reg.load_buffer[0] || !s_reg.first_step) begin
            sq_step = ICTR_STEP_TWO;
        end else if (s_reg.out) begin
            sq_step = ICTR_STEP_ONE;
        end else begin
            sq_step = ICTR_STEP_THREE;
        end
        sq_rest = dec_by(s_reg.ce, sq_step, s_reg.bcd);
    end

    always_comb begin
        s_next   = s_reg;
        cnt_done = 1'b0;
        cnt_word = s_reg.load_buffer;

        // Gate rise is held until the next counter clock rise.
        if (clk_e.rise) begin
            s_next.gate_hi   = gate_e.lvl;
            s_next.trig_seen = s_reg.trig_ff;
            s_next.trig_ff   = 1'b0;
        end
        if (gate_e.rise) begin
            s_next.trig_ff = 1'b1;
        end

        // A counter clock pulse completes on its falling edge.
        if (clk_e.fall) begin
            s_next.trig_seen = 1'b0;
            case (s_reg.mode)
            ICTR_M0_TERMINAL, ICTR_M4_STROBE: begin
                if (s_reg.load_pend) begin
                    s_next.ce        = s_reg.load_buffer;
                    s_next.load_pend = 1'b0;
                    s_next.null_cnt  = 1'b0;
                    s_next.running   = 1'b1;
                    s_next.out       = (s_reg.mode == ICTR_M4_STROBE);
                // A half-written count holds only mode 0; mode 4 counts on.
                end else if (s_reg.running && s_reg.gate_hi
                             && !(s_reg.lsb_wait && s_reg.mode
                                  == ICTR_M0_TERMINAL)) begin
                    s_next.ce = dec_one;
                    if (s_reg.mode == ICTR_M0_TERMINAL) begin
                        if (dec_one == ICTR_CE_ZERO) begin
                            s_next.out = 1'b1;
                        end
                    end else begin
                        s_next.out = 1'b1;
                        if (dec_one == ICTR_CE_ZERO && s_reg.first_step) begin
                            s_next.out        = 1'b0;
                            s_next.first_step = 1'b0;
                        end
                    end
                end
            end
            ICTR_M1_ONESHOT: begin
                if (s_reg.trig_seen && s_reg.have_cnt) begin
                    s_next.ce       = s_reg.load_buffer;
                    s_next.null_cnt = 1'b0;
                    s_next.running  = 1'b1;
                    s_next.out      = 1'b0;
                end else if (s_reg.running) begin
                    s_next.ce = dec_one;
                    if (dec_one == ICTR_CE_ZERO) begin
                        s_next.out = 1'b1;
                    end
                end
            end
            ICTR_M2_RATE: begin
                if ((s_reg.trig_seen && s_reg.have_cnt)
                    || s_reg.load_pend) begin
                    s_next.ce        = s_reg.load_buffer;
                    s_next.load_pend = 1'b0;
                    s_next.null_cnt  = 1'b0;
                    s_next.running   = 1'b1;
                    s_next.out       = 1'b1;
                end else if (s_reg.running && s_reg.gate_hi) begin
                    if (s_reg.ce == ICTR_CE_ONE) begin
                        s_next.ce       = s_reg.load_buffer;
                        s_next.null_cnt = 1'b0;
                        s_next.out      = 1'b1;
                    end else begin
                        s_next.ce  = dec_one;
                        s_next.out = (dec_one != ICTR_CE_ONE);
                    end
                end
            end
            ICTR_M3_SQUARE: begin
                if ((s_reg.trig_seen && s_reg.have_cnt)
                    || s_reg.load_pend) begin
                    s_next.ce         = s_reg.load_buffer;
                    s_next.load_pend  = 1'b0;
                    s_next.null_cnt   = 1'b0;
                    s_next.running    = 1'b1;
                    s_next.first_step = 1'b1;
                    s_next.out        = 1'b1;
                end else if (s_reg.running && s_reg.gate_hi) begin
                    if (sq_rest == ICTR_CE_ZERO) begin
                        // Expiry pulse doubles as the reload pulse.
                        s_next.out        = ~s_reg.out;
                        s_next.ce         = s_reg.load_buffer;
                        s_next.null_cnt   = 1'b0;
                        s_next.first_step = 1'b1;
                    end else begin
                        s_next.ce         = sq_rest;
                        s_next.first_step = 1'b0;
                    end
                end
            end
            default: begin
                s_next.out = 1'b1;
            end
            endcase
        end

        // Gate low lifts the output of the periodic modes at once.
        if (!gate_e.lvl && (s_reg.mode == ICTR_M2_RATE
                            || s_reg.mode == ICTR_M3_SQUARE)) begin
            s_next.out = 1'b1;
        end

        // Count writes; they land after pulse handling so a write in the
        // same cycle as a clock fall still loads on the following pulse.
        if (cnt_wr) begin
            case (s_reg.rw)
            ICTR_RW_MSB: begin
                cnt_word = {cnt_byte, ICTR_BYTE_ZERO};
                cnt_done = 1'b1;
            end
            ICTR_RW_BOTH: begin
                if (!s_reg.lsb_wait) begin
                    s_next.lsb_hold = cnt_byte;
                    s_next.lsb_wait = 1'b1;
                    if (s_reg.mode == ICTR_M0_TERMINAL) begin
                        s_next.out = 1'b0;
                    end
                end else begin
                    cnt_word        = {cnt_byte, s_reg.lsb_hold};
                    s_next.lsb_wait = 1'b0;
                    cnt_done        = 1'b1;
                end
            end
            default: begin
                cnt_word = {ICTR_BYTE_ZERO, cnt_byte};
                cnt_done = 1'b1;
            end
            endcase
        end
        if (cnt_done) begin
            s_next.load_buffer = cnt_word;
            s_next.null_cnt    = 1'b1;
            s_next.have_cnt    = 1'b1;
            case (s_reg.mode)
            ICTR_M0_TERMINAL: begin
                s_next.load_pend = 1'b1;
                s_next.out       = 1'b0;
            end
            ICTR_M4_STROBE: begin
                s_next.load_pend  = 1'b1;
                s_next.first_step = 1'b1;
            end
            ICTR_M2_RATE, ICTR_M3_SQUARE: begin
                s_next.load_pend = ~s_reg.running;
            end
            default: begin
                s_next.load_pend = 1'b0;
            end
            endcase
        end

        // A control word resets the counter's control logic at once.
        if (cw_wr) begin
            s_next.mode       = cw.mode;
            s_next.rw         = cw.rw;
            s_next.bcd        = cw.bcd;
            s_next.out        = (cw.mode != ICTR_M0_TERMINAL);
            s_next.lsb_wait   = 1'b0;
            s_next.load_pend  = 1'b0;
            s_next.have_cnt   = 1'b0;
            s_next.running    = 1'b0;
            s_next.trig_ff    = 1'b0;
            s_next.trig_seen  = 1'b0;
            s_next.first_step = 1'b0;
            s_next.null_cnt   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg             <= '0;
            s_reg.mode        <= ICTR_MODE_RESET;
            s_reg.rw          <= ICTR_RW_RESET;
            s_reg.load_buffer <= ICTR_CR_RESET;
            s_reg.ce          <= ICTR_CE_ZERO;
            s_reg.out         <= ICTR_OUT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pulse_out    = s_reg.out;
    assign count_now    = s_reg.ce;
    assign null_count   = s_reg.null_cnt;
    assign byte_pending = s_reg.lsb_wait;

endmodule // ictr_counter

/* File: verilog/ictr_pkg.sv */
// Constants and types shared by the interval counter files.
package ictr_pkg;

    // Counting modes as written in the control word.
    typedef enum logic [2:0] {
        ICTR_M0_TERMINAL = 3'b000,
        ICTR_M1_ONESHOT  = 3'b001,
        ICTR_M2_RATE     = 3'b010,
        ICTR_M3_SQUARE   = 3'b011,
        ICTR_M4_STROBE   = 3'b100
    } ictr_mode_t;

    // Byte order used for count writes.
    typedef enum logic [1:0] {
        ICTR_RW_LSB  = 2'b01,
        ICTR_RW_MSB  = 2'b10,
        ICTR_RW_BOTH = 2'b11
    } ictr_rw_t;

    // Control word as presented on the write port.
    typedef struct packed {
        ictr_rw_t   rw;
        ictr_mode_t mode;
        logic       bcd;
    } ictr_cw_t;

    // Sampled copy of one input pin with its edges.
    typedef struct packed {
        logic smp;
        logic lvl;
        logic rise;
        logic fall;
        logic live;
    } ictr_edge_t;

    // Whole state of one counter.
    typedef struct packed {
        ictr_mode_t  mode;
        ictr_rw_t    rw;
        logic        bcd;
        logic [15:0] load_buffer;
        logic [15:0] ce;
        logic [7:0]  lsb_hold;
        logic        lsb_wait;
        logic        out;
        logic        load_pend;
        logic        have_cnt;
        logic        running;
        logic        trig_ff;
        logic        trig_seen;
        logic        gate_hi;
        logic        first_step;
        logic        null_cnt;
    } ictr_state_t;

    localparam logic [15:0] ICTR_CE_ZERO   = 16'h0000;
    localparam logic [15:0] ICTR_CE_ONE    = 16'h0001;
    localparam logic [15:0] ICTR_CR_RESET  = 16'h0000;
    localparam logic [7:0]  ICTR_BYTE_ZERO = 8'h00;
    localparam logic [1:0]  ICTR_STEP_ONE  = 2'h1;
    localparam logic [1:0]  ICTR_STEP_TWO  = 2'h2;
    localparam logic [1:0]  ICTR_STEP_THREE = 2'h3;
    localparam int          ICTR_BCD_DIGITS = 4;
    localparam logic [3:0]  ICTR_BCD_NINE  = 4'h9;
    localparam ictr_mode_t  ICTR_MODE_RESET = ICTR_M0_TERMINAL;
    localparam ictr_rw_t    ICTR_RW_RESET   = ICTR_RW_LSB;
    localparam logic        ICTR_OUT_RESET  = 1'b0;

endpackage

/* File: verilog/ictr_edge.sv */
// Samples one pin and flags its rising and falling edges.
`timescale 1ns/100ps
module ictr_edge (
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                rst,
    // Pin to watch.
    input  wire logic                sig,
    // Sampled level and one-cycle edge pulses.
    output ictr_pkg::ictr_edge_t     edge_o
);
    import ictr_pkg::*;

    ictr_edge_t e_reg;
    ictr_edge_t e_next;

    // The first sample after reset seeds both stages, so a pin that rests
    // high is not taken for a rising edge once reset is released.
    always_comb begin
        e_next.smp  = sig;
        e_next.lvl  = e_reg.live ? e_reg.smp : sig;
        e_next.rise = e_reg.live & e_reg.smp & ~e_reg.lvl;
        e_next.fall = e_reg.live & ~e_reg.smp & e_reg.lvl;
        e_next.live = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            e_reg <= '0;
        end else begin
            e_reg <= e_next;
        end
    end

    assign edge_o = e_reg;

endmodule // ictr_edge

/* File: testbench/ictr_counter_properties.sv */
// Port checks for one interval counter.
`timescale 1ns/100ps
module ictr_counter_properties (
    // Clock and reset.
    input wire logic          clk,
    input wire logic          rst,
    // Host writes.
    input wire logic          cw_wr,
    input ictr_pkg::ictr_cw_t cw,
    input wire logic          cnt_wr,
    // Counter pins and status.
    input wire logic          cnt_clk,
    input wire logic          gate,
    input wire logic          pulse_out,
    input wire logic [15:0]   count_now,
    input wire logic          byte_pending
);
    import ictr_pkg::*;
    // Mode last written, so each check knows which rules apply.
    ictr_mode_t mode_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= ICTR_MODE_RESET;
        end else if (cw_wr) begin
            mode_reg <= cw.mode;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_gate_drop;
        (mode_reg == ICTR_M2_RATE || mode_reg == ICTR_M3_SQUARE)
            && $fell(gate) && !cw_wr ##1 (!gate && !cw_wr) [*2];
    endsequence
    sequence s_m2_low;
        count_now == ICTR_CE_ONE ##1 !pulse_out [*2];
    endsequence
    property p_m0_cw_low;
        cw_wr && cw.mode == ICTR_M0_TERMINAL |=> !pulse_out;
    endproperty
    property p_m0_rise;
        mode_reg == ICTR_M0_TERMINAL && $rose(pulse_out)
            |-> count_now == ICTR_CE_ZERO;
    endproperty
    property p_m1_cw_high;
        cw_wr && cw.mode == ICTR_M1_ONESHOT |=> pulse_out;
    endproperty
    property p_m1_rise;
        mode_reg == ICTR_M1_ONESHOT && $rose(pulse_out) && !$past(cw_wr)
            |-> count_now == ICTR_CE_ZERO;
    endproperty
    property p_m4_strobe;
        mode_reg == ICTR_M4_STROBE && $fell(pulse_out)
            |-> count_now == ICTR_CE_ZERO;
    endproperty
    property p_m2_low;
        mode_reg == ICTR_M2_RATE && $fell(pulse_out) |-> s_m2_low;
    endproperty
    property p_gate_force;
        s_gate_drop |=> pulse_out;
    endproperty
    property p_clk_fall;
        mode_reg != ICTR_M0_TERMINAL && mode_reg != ICTR_M3_SQUARE
            && $fell(pulse_out) |-> !$past(cnt_clk, 2);
    endproperty
    property p_cw_clear;
        cw_wr |=> !byte_pending;
    endproperty
    property p_m0_first;
        mode_reg == ICTR_M0_TERMINAL && $rose(byte_pending) |-> !pulse_out;
    endproperty
    a_m0_cw_low: assert property (p_m0_cw_low)
        else $error("mode 0 control word left output high");
    a_m0_rise: assert property (p_m0_rise)
        else $error("mode 0 output rose away from zero");
    a_m1_cw_high: assert property (p_m1_cw_high)
        else $error("mode 1 control word left output low");
    a_m1_rise: assert property (p_m1_rise)
        else $error("mode 1 output rose away from zero");
    a_m4_strobe: assert property (p_m4_strobe)
        else $error("mode 4 strobe away from zero");
    a_m2_low: assert property (p_m2_low)
        else $error("mode 2 low pulse wrong");
    a_gate_force: assert property (p_gate_force)
        else $error("gate low did not force output high");
    a_clk_fall: assert property (p_clk_fall)
        else $error("output fell without a counter clock fall");
    a_cw_clear: assert property (p_cw_clear)
        else $error("control word kept half count flag");
    a_m0_first: assert property (p_m0_first)
        else $error("mode 0 first byte left output high");
endmodule // ictr_counter_properties

bind ictr_counter ictr_counter_properties i_ictr_counter_properties (
    .clk(clk), .rst(rst), .cw_wr(cw_wr), .cw(cw), .cnt_wr(cnt_wr),
    .cnt_clk(cnt_clk), .gate(gate), .pulse_out(pulse_out),
    .count_now(count_now), .byte_pending(byte_pending));

/* File: testbench/ictr_host_model.sv */
// Host processor model that writes control words and count bytes.
`timescale 1ns/100ps
module ictr_host_model (
    // Clock.
    input wire logic          clk,
    // Writes toward the counter.
    output ictr_pkg::ictr_cw_t cw,
    output logic              cw_wr,
    output logic              cnt_wr,
    output logic [7:0]        cnt_byte
);
    import ictr_pkg::*;
    initial begin
        cw = '0;
        cw_wr = 1'b0;
        cnt_wr = 1'b0;
        cnt_byte = ICTR_BYTE_ZERO;
    end
    // Each strobe stands for exactly one edge, then one idle edge.
    task automatic write_cw(input ictr_rw_t rw, input ictr_mode_t m,
                            input logic bcd_en = 1'b0);
        @(posedge clk);
        cw_wr <= 1'b1;
        cw <= '{rw: rw, mode: m, bcd: bcd_en};
        @(posedge clk);
        cw_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    // Two-byte counts are sent low byte first by the caller.
    task automatic write_cnt(input logic [7:0] b);
        @(posedge clk);
        cnt_wr <= 1'b1;
        cnt_byte <= b;
        @(posedge clk);
        cnt_wr <= 1'b0;
        cnt_byte <= ~b;
        @(posedge clk);
        #1;
    endtask
endmodule // ictr_host_model

/* File: testbench/test_interval_counter_modes_0_to_4.sv */
// Self-checking bench for the interval counter modes 0 to 4.
`timescale 1ns/100ps
module test_interval_counter_modes_0_to_4;
    import ictr_pkg::*;
    logic        clk;
    logic        rst;
    ictr_cw_t    cw;
    logic        cw_wr;
    logic        cnt_wr;
    logic [7:0]  cnt_byte;
    logic        cnt_clk;
    logic        gate;
    logic        pulse_out;
    logic [15:0] count_now;
    logic        null_count;
    logic        byte_pending;
    int          miscompares;
    int          n_checks;
    ictr_host_model i_ictr_host_model (.clk(clk), .cw(cw), .cw_wr(cw_wr),
        .cnt_wr(cnt_wr), .cnt_byte(cnt_byte));
    ictr_counter i_ictr_counter (.clk(clk), .rst(rst), .cw_wr(cw_wr),
        .cw(cw), .cnt_wr(cnt_wr), .cnt_byte(cnt_byte), .cnt_clk(cnt_clk),
        .gate(gate), .pulse_out(pulse_out), .count_now(count_now),
        .null_count(null_count), .byte_pending(byte_pending));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic wcw(input ictr_rw_t rw, input ictr_mode_t m,
                       input logic bcd_en = 1'b0);
        i_ictr_host_model.write_cw(rw, m, bcd_en);
    endtask
    task automatic wcnt(input logic [7:0] b);
        i_ictr_host_model.write_cnt(b);
    endtask
    // One counter clock pulse, long enough for the pin samplers.
    task automatic cpulse();
        @(posedge clk);
        cnt_clk <= 1'b1;
        repeat (4) @(posedge clk);
        cnt_clk <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic set_gate(input logic v);
        @(posedge clk);
        gate <= v;
        repeat (5) @(posedge clk);
        #1;
    endtask
    // Bit i of pat is the output level after pulse i plus one.
    task automatic run(input int n, input logic [15:0] pat);
        for (int i = 0; i < n; i++) begin
            cpulse();
            cmp1(pulse_out, pat[i]);
        end
    endtask
    task automatic t_m0();
        wcw(ICTR_RW_LSB, ICTR_M0_TERMINAL);
        cmp1(pulse_out, 1'b0);
        wcnt(8'h03);
        cmp1(null_count, 1'b1);
        run(4, 16'h0008);
        cmp1(null_count, 1'b0);
        wcnt(8'h02);
        run(3, 16'h0004);
    endtask
    task automatic t_m0_gate();
        wcw(ICTR_RW_LSB, ICTR_M0_TERMINAL);
        set_gate(1'b0);
        wcnt(8'h02);
        run(2, 16'h0000);
        cmp16(count_now, 16'h0002);
        set_gate(1'b1);
        run(2, 16'h0002);
    endtask
    task automatic t_m0_two();
        wcw(ICTR_RW_BOTH, ICTR_M0_TERMINAL);
        wcnt(8'h02);
        cmp1(byte_pending, 1'b1);
        wcnt(8'h00);
        run(3, 16'h0004);
        wcnt(8'h05);
        cmp1(pulse_out, 1'b0);
        run(2, 16'h0000);
        cmp16(count_now, 16'h0000);
        wcnt(8'h00);
        cmp1(byte_pending, 1'b0);
        run(6, 16'h0020);
    endtask
    task automatic t_zero();
        wcw(ICTR_RW_LSB, ICTR_M0_TERMINAL);
        wcnt(8'h00);
        run(2, 16'h0000);
        cmp16(count_now, 16'hffff);
    endtask
    task automatic t_bcd();
        wcw(ICTR_RW_MSB, ICTR_M0_TERMINAL, 1'b1);
        wcnt(8'h01);
        run(2, 16'h0000);
        cmp16(count_now, 16'h0099);
        wcnt(8'h00);
        run(2, 16'h0000);
        cmp16(count_now, 16'h9999);
    endtask
    task automatic t_m1();
        set_gate(1'b0);
        wcw(ICTR_RW_LSB, ICTR_M1_ONESHOT);
        cmp1(pulse_out, 1'b1);
        wcnt(8'h03);
        run(1, 16'h0001);
        set_gate(1'b1);
        run(5, 16'h0018);
        set_gate(1'b0);
        set_gate(1'b1);
        run(2, 16'h0000);
        wcnt(8'h05);
        run(1, 16'h0000);
        cmp16(count_now, 16'h0001);
        set_gate(1'b0);
        set_gate(1'b1);
        run(6, 16'h0020);
    endtask
    task automatic t_m2();
        wcw(ICTR_RW_LSB, ICTR_M2_RATE);
        cmp1(pulse_out, 1'b1);
        wcnt(8'h03);
        run(6, 16'h001b);
        set_gate(1'b0);
        cmp1(pulse_out, 1'b1);
        set_gate(1'b1);
        run(3, 16'h0003);
    endtask
    task automatic t_m3();
        wcw(ICTR_RW_LSB, ICTR_M3_SQUARE);
        wcnt(8'h05);
        run(9, 16'h00e7);
        wcw(ICTR_RW_LSB, ICTR_M3_SQUARE);
        wcnt(8'h04);
        run(8, 16'h0033);
        set_gate(1'b0);
        cmp1(pulse_out, 1'b1);
        set_gate(1'b1);
    endtask
    task automatic t_m4();
        wcw(ICTR_RW_BOTH, ICTR_M4_STROBE);
        cmp1(pulse_out, 1'b1);
        wcnt(8'h02);
        wcnt(8'h00);
        run(3, 16'h0003);
        wcnt(8'h05);
        run(1, 16'h0001);
        cmp16(count_now, 16'hffff);
        wcnt(8'h00);
        run(6, 16'h001f);
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        miscompares = 0;
        n_checks = 0;
        rst = 1'b1;
        gate = 1'b1;
        cnt_clk = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_m0();
        t_m0_gate();
        t_m0_two();
        t_zero();
        t_bcd();
        t_m1();
        t_m2();
        t_m3();
        t_m4();
        conclude();
    end
endmodule // test_interval_counter_modes_0_to_4
